// ---- rtl/scpi_front.sv ----
// Remote command front end: serial, GPIB and LAN intake, parser, error list.
`timescale 1ns/10ps
module scpi_front #(
  parameter logic [15:0] BAUD_DIV = scpi_front_pkg::BAUD_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_ce,
  input  wire logic                   i_uart_rx,
  input  wire scpi_front_pkg::gpib_t  i_gpib,
  input  wire logic [4:0]             i_gpib_addr,
  input  wire scpi_front_pkg::lan_t   i_lan,
  input  wire scpi_front_pkg::fault_t i_fault,
  output logic                        o_gpib_ready,
  output logic                        o_lan_ready,
  output logic                        o_gpib_listen,
  output logic                        o_gpib_talk,
  output scpi_front_pkg::cmd_t        o_cmd,
  output logic                        o_cmd_valid,
  output scpi_front_pkg::byte_t       o_str,
  output logic [3:0]                  o_err_resp,
  output logic                        o_err_resp_valid,
  output logic [3:0]                  o_last_err,
  output logic [3:0]                  o_err_count
);
  typedef struct packed {
    logic [1:0]           rx_sync;
    logic                 rx_busy;
    logic [15:0]          rx_cnt;
    logic [3:0]           rx_bit;
    logic [7:0]           rx_sh;
    logic                 rx_v;
    logic                 listen;
    logic                 talk;
    scpi_front_pkg::parse_t st;
    logic                 cr;
    logic                 bad;
    logic                 arg_seen;
    logic                 neg;
    logic                 dot;
    logic                 digits;
    logic [7:0]           quote;
    logic [23:0]          word;
    logic [10:0]          pend;
    logic [9:0][3:0]      q;
    logic [3:0]           rd;
    logic [3:0]           cnt;
    scpi_front_pkg::cmd_t cmd;
    logic                 cmd_v;
    scpi_front_pkg::byte_t sb;
    logic [3:0]           resp;
    logic                 resp_v;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30) && (c <= 8'h39);
  endfunction

  function automatic logic [3:0] wrap(input logic [3:0] p);
    wrap = (p == 4'(scpi_front_pkg::ERR_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  logic       addr_ok;
  logic       gpib_byte;
  logic       lan_port_ok;
  logic       lan_byte;
  logic [7:0] ch;
  logic       ch_v;

  always_comb begin
    addr_ok     = (i_gpib_addr >= scpi_front_pkg::ADDR_MIN)
               && (i_gpib_addr <= scpi_front_pkg::ADDR_MAX);
    gpib_byte   = i_gpib.valid && !i_gpib.atn && s_r.listen;
    lan_port_ok = (i_lan.port == scpi_front_pkg::PORT_TELNET)
               || (i_lan.port == scpi_front_pkg::PORT_SOCKET);
    lan_byte    = i_lan.valid && lan_port_ok;
    // The serial receiver cannot be paused, so it always wins the parser.
    o_gpib_ready = !s_r.rx_v;
    o_lan_ready  = !s_r.rx_v && !gpib_byte;
    if (s_r.rx_v) begin
      ch   = s_r.rx_sh;
      ch_v = 1'b1;
    end else if (gpib_byte) begin
      ch   = i_gpib.data;
      ch_v = 1'b1;
    end else begin
      ch   = i_lan.data;
      ch_v = lan_byte;
    end
  end

  logic [7:0]  uc;
  logic [3:0]  push_code;
  logic        push;
  logic        pop;
  logic        clr;
  logic        fin;
  logic [31:0] acc;
  logic [10:0] pend_set;

  always_comb begin
    s_nxt        = s_r;
    uc           = upcase(ch);
    push         = 1'b0;
    push_code    = scpi_front_pkg::E_NONE;
    pop          = 1'b0;
    clr          = 1'b0;
    fin          = 1'b0;
    acc          = s_r.cmd.value * 32'd10 + {28'h0, ch[3:0]};
    s_nxt.rx_v   = 1'b0;
    s_nxt.cmd_v  = 1'b0;
    s_nxt.sb     = '0;
    s_nxt.resp_v = 1'b0;

    // Serial receiver, 8 data bits, no parity, one stop bit.
    s_nxt.rx_sync = {s_r.rx_sync[0], i_uart_rx};
    if (!s_r.rx_busy) begin
      if (!s_r.rx_sync[1]) begin
        s_nxt.rx_busy = 1'b1;
        s_nxt.rx_cnt  = {1'b0, BAUD_DIV[15:1]};
        s_nxt.rx_bit  = 4'h0;
      end
    end else if (s_r.rx_cnt != 16'h0) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
    end else begin
      s_nxt.rx_cnt = BAUD_DIV - 16'h1;
      s_nxt.rx_bit = s_r.rx_bit + 4'h1;
      if (s_r.rx_bit == 4'h0) begin
        // A start bit that has gone high again was a glitch.
        s_nxt.rx_busy = !s_r.rx_sync[1];
      end else if (s_r.rx_bit <= 4'h8) begin
        s_nxt.rx_sh = {s_r.rx_sync[1], s_r.rx_sh[7:1]};
      end else begin
        s_nxt.rx_busy = 1'b0;
        s_nxt.rx_v    = s_r.rx_sync[1];
      end
    end

    // Bus addressing on command bytes; only addresses 1 to 30 are accepted.
    if (i_gpib.valid && i_gpib.atn) begin
      if (i_gpib.data == scpi_front_pkg::GPIB_UNL) begin
        s_nxt.listen = 1'b0;
      end else if (i_gpib.data == scpi_front_pkg::GPIB_UNT) begin
        s_nxt.talk = 1'b0;
      end else if (addr_ok) begin
        if (i_gpib.data == (scpi_front_pkg::GPIB_LAG | {3'h0, i_gpib_addr}))
          s_nxt.listen = 1'b1;
        else if (i_gpib.data ==
                 (scpi_front_pkg::GPIB_TAG | {3'h0, i_gpib_addr}))
          s_nxt.talk = 1'b1;
      end
    end
    if (!addr_ok) begin
      s_nxt.listen = 1'b0;
      s_nxt.talk   = 1'b0;
    end

    // Command parser.
    if (ch_v) begin
      s_nxt.cr = (ch == scpi_front_pkg::CH_CR);
      if (ch == scpi_front_pkg::CH_LF && s_r.cr) begin
        fin = 1'b1;
      end else if (ch == scpi_front_pkg::CH_CR
                   && s_r.st != scpi_front_pkg::P_STR) begin
        s_nxt.cr = 1'b1;
      end else begin
        unique case (s_r.st)
          scpi_front_pkg::P_HDR: begin
            if (ch == scpi_front_pkg::CH_SP) begin
              s_nxt.st = scpi_front_pkg::P_ARG;
              if (s_r.cmd.hdr_len == 4'h0)
                s_nxt.bad = 1'b1;
            end else if (s_r.cmd.hdr_len == 4'h8) begin
              s_nxt.bad = 1'b1;
            end else begin
              s_nxt.cmd.hdr     = {s_r.cmd.hdr[6:0], uc};
              s_nxt.cmd.hdr_len = s_r.cmd.hdr_len + 4'h1;
            end
          end
          scpi_front_pkg::P_ARG: begin
            s_nxt.arg_seen = 1'b1;
            if (ch == scpi_front_pkg::CH_SP) begin
              s_nxt.bad = 1'b1;
            end else if (!s_r.arg_seen && (ch == scpi_front_pkg::CH_DQ
                         || ch == scpi_front_pkg::CH_SQ)) begin
              s_nxt.quote    = ch;
              s_nxt.cmd.kind = scpi_front_pkg::K_STR;
              s_nxt.st       = scpi_front_pkg::P_STR;
            end else if (!s_r.arg_seen && (ch == scpi_front_pkg::CH_MINUS
                         || ch == scpi_front_pkg::CH_PLUS)) begin
              s_nxt.neg      = (ch == scpi_front_pkg::CH_MINUS);
              s_nxt.cmd.kind = scpi_front_pkg::K_NUM;
            end else if (is_digit(ch) && s_r.cmd.kind
                         != scpi_front_pkg::K_WORD) begin
              s_nxt.cmd.kind  = scpi_front_pkg::K_NUM;
              s_nxt.digits    = 1'b1;
              s_nxt.cmd.value = acc;
              if (s_r.dot)
                s_nxt.cmd.frac_digits = s_r.cmd.frac_digits + 4'h1;
            end else if (ch == scpi_front_pkg::CH_DOT && !s_r.dot
                         && s_r.cmd.kind != scpi_front_pkg::K_WORD) begin
              s_nxt.dot      = 1'b1;
              s_nxt.cmd.kind = scpi_front_pkg::K_NUM;
            end else if (s_r.cmd.kind != scpi_front_pkg::K_NUM
                         && uc >= 8'h41 && uc <= 8'h5a) begin
              s_nxt.cmd.kind = scpi_front_pkg::K_WORD;
              s_nxt.word     = {s_r.word[15:0], uc};
              if (s_r.word[23:16] != 8'h0)
                s_nxt.bad = 1'b1;
            end else begin
              s_nxt.bad = 1'b1;
            end
          end
          scpi_front_pkg::P_STR: begin
            if (ch == s_r.quote) begin
              s_nxt.st = scpi_front_pkg::P_SKIP;
            end else begin
              s_nxt.sb.valid    = 1'b1;
              s_nxt.sb.data     = ch;
              s_nxt.cmd.str_len = s_r.cmd.str_len + 8'h1;
            end
          end
          scpi_front_pkg::P_SKIP: begin
            // Only the terminator may follow a closed string.
            s_nxt.bad = 1'b1;
          end
          default: begin
            s_nxt.st  = scpi_front_pkg::P_SKIP;
            s_nxt.bad = 1'b1;
          end
        endcase
      end
    end

    if (fin) begin
      s_nxt.cmd.is_int   = s_r.cmd.kind == scpi_front_pkg::K_NUM
                        && !s_r.dot;
      s_nxt.cmd.bool_ok  = 1'b0;
      s_nxt.cmd.bool_val = 1'b0;
      if (s_r.neg)
        s_nxt.cmd.value = 32'h0 - s_r.cmd.value;
      if (s_r.cmd.kind == scpi_front_pkg::K_WORD) begin
        s_nxt.cmd.bool_ok  = (s_r.word == scpi_front_pkg::WORD_ON)
                          || (s_r.word == scpi_front_pkg::WORD_OFF);
        s_nxt.cmd.bool_val = (s_r.word == scpi_front_pkg::WORD_ON);
      end else if (s_r.cmd.kind == scpi_front_pkg::K_NUM && !s_r.dot
                   && !s_r.neg && s_r.cmd.value[31:1] == 31'h0) begin
        s_nxt.cmd.bool_ok  = 1'b1;
        s_nxt.cmd.bool_val = s_r.cmd.value[0];
      end
      if (s_r.bad || s_r.st == scpi_front_pkg::P_STR
          || (s_r.cmd.kind == scpi_front_pkg::K_NUM && !s_r.digits)
          || s_r.cmd.hdr_len == 4'h0) begin
        push      = 1'b1;
        push_code = scpi_front_pkg::E_CMD;
      end else if (s_r.cmd.hdr == scpi_front_pkg::HDR_CLS) begin
        clr = 1'b1;
      end else if (s_r.cmd.hdr == scpi_front_pkg::HDR_ERR
                   || s_r.cmd.hdr == scpi_front_pkg::HDR_ERROR) begin
        pop          = s_r.cnt != 4'h0;
        s_nxt.resp_v = 1'b1;
        s_nxt.resp   = (s_r.cnt != 4'h0) ? s_r.q[s_r.rd]
                                         : scpi_front_pkg::E_NONE;
      end else begin
        s_nxt.cmd_v = 1'b1;
      end
      s_nxt.st       = scpi_front_pkg::P_HDR;
      s_nxt.bad      = 1'b0;
      s_nxt.arg_seen = 1'b0;
      s_nxt.neg      = 1'b0;
      s_nxt.dot      = 1'b0;
      s_nxt.digits   = 1'b0;
      s_nxt.word     = 24'h0;
      s_nxt.cr       = 1'b0;
    end
    if (s_r.cmd_v || s_r.resp_v || (fin && (push || clr))) begin
      // Fields of the finished command are held until its pulse has passed.
      // A clear has no pulse, so its header must not leak into the next.
      s_nxt.cmd.hdr         = 64'h0;
      s_nxt.cmd.hdr_len     = 4'h0;
      s_nxt.cmd.kind        = scpi_front_pkg::K_NONE;
      s_nxt.cmd.value       = 32'h0;
      s_nxt.cmd.frac_digits = 4'h0;
      s_nxt.cmd.str_len     = 8'h0;
    end

    // Fault events wait as pending bits, one enters the list per cycle.
    pend_set = {i_fault.sync_bad && !i_fault.out_on,
                i_fault.sync_bad && i_fault.out_on,
                i_fault.slave_fail[2],
                i_fault.slave_fail[1],
                i_fault.slave_fail[0],
                i_fault.no_slave,
                i_fault.multi_master,
                i_fault.mode_bad,
                i_fault.range_err,
                i_fault.query_err,
                i_fault.exec_err};
    if (!push) begin
      for (int i = 10; i >= 0; i--) begin
        if (s_r.pend[i]) begin
          push      = 1'b1;
          push_code = 4'(i) + scpi_front_pkg::E_EXEC;
        end
      end
      if (push)
        s_nxt.pend[push_code - scpi_front_pkg::E_EXEC] = 1'b0;
    end
    // A new event in the cycle of its service is kept.
    s_nxt.pend = s_nxt.pend | pend_set;

    // Error list, oldest first.
    if (clr) begin
      s_nxt.cnt = 4'h0;
      s_nxt.rd  = 4'h0;
    end else if (pop) begin
      s_nxt.rd  = wrap(s_r.rd);
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    if (push) begin
      if (clr) begin
        s_nxt.q[0] = push_code;
        s_nxt.cnt  = 4'h1;
      end else if (s_r.cnt != 4'(scpi_front_pkg::ERR_DEPTH)) begin
        s_nxt.q[4'((5'(s_r.rd) + 5'(s_r.cnt))
                   % 5'(scpi_front_pkg::ERR_DEPTH))] = push_code;
        s_nxt.cnt = s_nxt.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r          <= '0;
      s_r.rx_sync  <= 2'h3;
      s_r.st       <= scpi_front_pkg::P_HDR;
      s_r.cmd.kind <= scpi_front_pkg::K_NONE;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_gpib_listen    = s_r.listen;
    o_gpib_talk      = s_r.talk;
    o_cmd            = s_r.cmd;
    o_cmd_valid      = s_r.cmd_v;
    o_str            = s_r.sb;
    o_err_resp       = s_r.resp;
    o_err_resp_valid = s_r.resp_v;
    o_last_err       = (s_r.cnt != 4'h0) ? s_r.q[s_r.rd]
                                         : scpi_front_pkg::E_NONE;
    o_err_count      = s_r.cnt;
  end
endmodule

// ---- rtl/scpi_front_pkg.sv ----
// Constants and carrier types for the remote command front end.
package scpi_front_pkg;
  localparam int          CLK_HZ      = 250000000;
  localparam int          BAUD        = 57600;
  localparam logic [15:0] BAUD_CYC    = 16'(CLK_HZ / BAUD);
  localparam logic [15:0] PORT_TELNET = 16'd5024;
  localparam logic [15:0] PORT_SOCKET = 16'd5025;
  localparam int          ERR_DEPTH   = 10;
  localparam logic [4:0]  ADDR_MIN    = 5'h01;
  localparam logic [4:0]  ADDR_MAX    = 5'h1e;
  localparam logic [7:0]  GPIB_LAG    = 8'h20;
  localparam logic [7:0]  GPIB_TAG    = 8'h40;
  localparam logic [7:0]  GPIB_UNL    = 8'h3f;
  localparam logic [7:0]  GPIB_UNT    = 8'h5f;
  localparam logic [7:0]  CH_CR       = 8'h0d;
  localparam logic [7:0]  CH_LF       = 8'h0a;
  localparam logic [7:0]  CH_SP       = 8'h20;
  localparam logic [7:0]  CH_DQ       = 8'h22;
  localparam logic [7:0]  CH_SQ       = 8'h27;
  localparam logic [7:0]  CH_MINUS    = 8'h2d;
  localparam logic [7:0]  CH_PLUS     = 8'h2b;
  localparam logic [7:0]  CH_DOT      = 8'h2e;
  localparam logic [63:0] HDR_CLS     = 64'h0000_0000_2a43_4c53;
  localparam logic [63:0] HDR_ERR     = 64'h0000_0000_4552_523f;
  localparam logic [63:0] HDR_ERROR   = 64'h0000_4552_524f_523f;
  localparam logic [23:0] WORD_ON     = 24'h00_4f4e;
  localparam logic [23:0] WORD_OFF    = 24'h4f_4646;
  localparam logic [3:0]  E_NONE      = 4'h0;
  localparam logic [3:0]  E_CMD       = 4'h1;
  localparam logic [3:0]  E_EXEC      = 4'h2;
  localparam logic [3:0]  E_SYNC_OFF  = 4'hc;

  typedef enum logic [3:0] {
    P_HDR  = 4'b0001,
    P_ARG  = 4'b0010,
    P_STR  = 4'b0100,
    P_SKIP = 4'b1000
  } parse_t;

  typedef enum logic [3:0] {
    K_NONE = 4'b0001,
    K_NUM  = 4'b0010,
    K_WORD = 4'b0100,
    K_STR  = 4'b1000
  } kind_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;

  typedef struct packed {
    logic       valid;
    logic       atn;
    logic [7:0] data;
  } gpib_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] port;
    logic [7:0]  data;
  } lan_t;

  typedef struct packed {
    logic       exec_err;
    logic       query_err;
    logic       range_err;
    logic       mode_bad;
    logic       multi_master;
    logic       no_slave;
    logic [2:0] slave_fail;
    logic       sync_bad;
    logic       out_on;
  } fault_t;

  typedef struct packed {
    logic [7:0][7:0] hdr;
    logic [3:0]      hdr_len;
    kind_t           kind;
    logic            is_int;
    logic            bool_ok;
    logic            bool_val;
    logic [31:0]     value;
    logic [3:0]      frac_digits;
    logic [7:0]      str_len;
  } cmd_t;
endpackage

// ---- testbench/scpi_front_properties.sv ----
// Port-level checks on the remote command front end.
`timescale 1ns/10ps
module scpi_front_properties #(
  parameter logic [15:0] BAUD_DIV = scpi_front_pkg::BAUD_CYC
) (
  input wire logic                  i_clk,
  input wire logic                  i_reset,
  input wire scpi_front_pkg::gpib_t i_gpib,
  input wire logic [4:0]            i_gpib_addr,
  input wire logic                  o_gpib_listen,
  input wire logic                  o_gpib_talk,
  input wire logic                  o_cmd_valid,
  input wire logic [3:0]            o_err_resp,
  input wire logic                  o_err_resp_valid,
  input wire logic [3:0]            o_last_err,
  input wire logic [3:0]            o_err_count
);
  logic lag_hit;
  logic tag_hit;

  assign lag_hit = i_gpib.valid && i_gpib.atn
                && i_gpib.data == 8'h20 + {3'h0, i_gpib_addr};
  assign tag_hit = i_gpib.valid && i_gpib.atn
                && i_gpib.data == 8'h40 + {3'h0, i_gpib_addr};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  count_max_a: assert property (o_err_count <= 4'ha)
    else $error("error list holds more than ten");
  empty_zero_a: assert property ((o_err_count == 4'h0) |->
    (o_last_err == 4'h0))
    else $error("empty list shows a code");
  code_range_a: assert property ((o_err_count != 4'h0) |->
    (o_last_err inside {[4'h1:4'hc]}))
    else $error("pending code out of range");
  fifo_head_a: assert property (o_err_resp_valid |->
    (o_err_resp == $past(o_last_err)))
    else $error("answer is not the oldest entry");
  pop_step_a: assert property (o_err_resp_valid && o_err_resp != 4'h0
    |-> (o_err_count == $past(o_err_count) - 4'h1 ||
     o_err_count == $past(o_err_count)))
    else $error("query did not remove its entry");
  resp_pulse_a: assert property (o_err_resp_valid |=> !o_err_resp_valid)
    else $error("answer pulse too long");
  full_keep_a: assert property ((o_err_count == 4'ha &&
    $past(o_err_count) == 4'ha) |-> $stable(o_last_err))
    else $error("full list changed");
  grow_one_a: assert property ((o_err_count > $past(o_err_count)) |->
    (o_err_count == $past(o_err_count) + 4'h1))
    else $error("list grew by more than one");
  listen_addr_a: assert property ($rose(o_gpib_listen) |->
    $past(lag_hit) && (i_gpib_addr inside {[5'h01:5'h1e]}))
    else $error("listen without own address");
  talk_addr_a: assert property ($rose(o_gpib_talk) |->
    $past(tag_hit))
    else $error("talk without own address");
  cmd_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command pulse too long");
endmodule

bind scpi_front scpi_front_properties #(.BAUD_DIV(BAUD_DIV)) u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_gpib(i_gpib),
  .i_gpib_addr(i_gpib_addr), .o_gpib_listen(o_gpib_listen),
  .o_gpib_talk(o_gpib_talk), .o_cmd_valid(o_cmd_valid),
  .o_err_resp(o_err_resp), .o_err_resp_valid(o_err_resp_valid),
  .o_last_err(o_last_err), .o_err_count(o_err_count));

// ---- testbench/host_uart.sv ----
// Host side serial transmitter, 8N1, line idles high between frames.
`timescale 1ns/10ps
module host_uart #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       i_clk,
  input  wire logic       i_send,
  input  wire logic [7:0] i_byte,
  output logic            o_tx,
  output logic            o_busy
);
  logic [9:0] bits;

  initial begin
    o_tx = 1'b1;
    o_busy = 1'b0;
  end

  // Start bit, eight data bits LSB first, one stop bit, no flow control.
  always @(posedge i_clk) begin
    if (i_send && !o_busy) begin
      o_busy <= 1'b1;
      bits = {1'b1, i_byte, 1'b0};
      for (int i = 0; i < 10; i++) begin
        o_tx <= bits[i];
        repeat (BIT_CYC) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
  end
endmodule

// ---- testbench/scpi_front_tb.sv ----
// Self-checking bench for the remote command front end.
`timescale 1ns/10ps
module scpi_front_tb;
  logic                   clk;
  logic                   reset;
  logic                   tx;
  logic                   send_r;
  logic [7:0]             sbyte;
  logic                   busy;
  logic [4:0]             addr;
  logic                   ce;
  scpi_front_pkg::gpib_t  gpib;
  scpi_front_pkg::lan_t   lan;
  scpi_front_pkg::fault_t fault;
  logic                   gpib_rdy;
  logic                   lan_rdy;
  logic                   listen;
  logic                   talk;
  scpi_front_pkg::cmd_t   cmd;
  logic                   cmd_v;
  scpi_front_pkg::byte_t  str;
  logic [3:0]             resp;
  logic                   resp_v;
  logic [3:0]             last;
  logic [3:0]             cnt;
  scpi_front_pkg::cmd_t   cmd_q;
  logic [3:0]             resp_q;
  logic [15:0]            sq;
  int                     n_cmd;
  int                     n_resp;
  int                     fails;
  int                     checks;

  // A short bit time keeps serial traffic within the run budget.
  scpi_front #(.BAUD_DIV(16'h0010)) dut (
    .i_clk(clk), .i_reset(reset), .i_ce(ce), .i_uart_rx(tx),
    .i_gpib(gpib), .i_gpib_addr(addr), .i_lan(lan), .i_fault(fault),
    .o_gpib_ready(gpib_rdy), .o_lan_ready(lan_rdy),
    .o_gpib_listen(listen), .o_gpib_talk(talk), .o_cmd(cmd),
    .o_cmd_valid(cmd_v), .o_str(str), .o_err_resp(resp),
    .o_err_resp_valid(resp_v), .o_last_err(last), .o_err_count(cnt));

  host_uart #(.BIT_CYC(16)) host (.i_clk(clk), .i_send(send_r),
    .i_byte(sbyte), .o_tx(tx), .o_busy(busy));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (cmd_v === 1'b1) begin
      cmd_q = cmd;
      n_cmd++;
    end
    if (resp_v === 1'b1) begin
      resp_q = resp;
      n_resp++;
    end
    if (str.valid === 1'b1)
      sq = {sq[7:0], str.data};
  end

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, exp, input string m);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [63:0] hdrv(input string s);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++)
      v = {v[55:0], s[i]};
    return v;
  endfunction

  // Holds the byte until the ready flag lets an edge take it.
  task automatic put(input bit g, input logic [15:0] p, input logic a,
                     input logic [7:0] b);
    int k;
    k = 0;
    if (g)
      gpib = '{1'b1, a, b};
    else
      lan = '{1'b1, p, b};
    while ((g ? gpib_rdy : lan_rdy) !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) begin
      chk(0, 1, "byte never taken");
      end_of_test();
    end
    @(negedge clk);
  endtask

  task automatic send(input string s, input bit g, input logic [15:0] p);
    for (int i = 0; i < s.len(); i++)
      put(g, p, 1'b0, s[i]);
    put(g, p, 1'b0, 8'h0d);
    put(g, p, 1'b0, 8'h0a);
    gpib.valid = 1'b0;
    lan.valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic atn(input logic [7:0] b);
    put(1'b1, 16'h0, 1'b1, b);
    gpib.valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic ser(input string s);
    int k;
    for (int i = 0; i < s.len() + 2; i++) begin
      sbyte = i < s.len() ? s[i] : (i == s.len() ? 8'h0d : 8'h0a);
      send_r = 1'b1;
      @(negedge clk);
      send_r = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 500) begin
        @(negedge clk);
        k++;
      end
      if (k == 500) begin
        chk(0, 1, "serial stuck");
        end_of_test();
      end
    end
  endtask

  task automatic await(input int c0, r0);
    int k;
    k = 0;
    while (n_cmd == c0 && n_resp == r0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k == 300) begin
      chk(0, 1, "no answer");
      end_of_test();
    end
  endtask

  task automatic wait_count(input logic [3:0] e);
    int k;
    k = 0;
    while (cnt !== e && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(cnt, e, "error count");
    if (cnt !== e)
      end_of_test();
  endtask

  task automatic pulse(input logic [10:0] v);
    fault = v;
    @(negedge clk);
    fault = '0;
    @(negedge clk);
  endtask

  task automatic t_bool();
    string w[4] = '{"ON", "OFF", "1", "0"};
    int c0;
    for (int i = 0; i < 4; i++) begin
      c0 = n_cmd;
      send({"OUT ", w[i]}, 1'b0, i[0] ? 16'd5025 : 16'd5024);
      await(c0, n_resp);
      chk(cmd_q.bool_ok, 1, "bool accepted");
      chk(cmd_q.bool_val, !i[0], "bool value");
      chk(cmd_q.hdr, hdrv("OUT"), "header split");
    end
    c0 = n_cmd;
    send("OUT 1", 1'b0, 16'd23);
    repeat (5) @(negedge clk);
    chk(n_cmd, c0, "foreign port ignored");
  endtask

  task automatic t_num();
    int c0;
    c0 = n_cmd;
    send("VSET -3.25", 1'b0, 16'd5024);
    await(c0, n_resp);
    chk(cmd_q.value, 32'hfffffebb, "fraction value");
    chk(cmd_q.frac_digits, 2, "fraction digits");
    chk(cmd_q.kind, scpi_front_pkg::K_NUM, "numeric kind");
    c0 = n_cmd;
    send("ISET -42", 1'b0, 16'd5025);
    await(c0, n_resp);
    chk(cmd_q.value, 32'hffffffd6, "integer value");
    chk(cmd_q.is_int, 1, "integer flag");
  endtask

  task automatic t_str();
    int c0;
    c0 = n_cmd;
    send("NAME 'ab'", 1'b0, 16'd5024);
    await(c0, n_resp);
    chk(sq, 16'h6162, "single quoted text");
    chk(cmd_q.kind, scpi_front_pkg::K_STR, "string kind");
    chk(cmd_q.str_len, 2, "string length");
    c0 = n_cmd;
    send("NAME \"cd\"", 1'b0, 16'd5024);
    await(c0, n_resp);
    chk(sq, 16'h6364, "double quoted text");
  endtask

  task automatic t_gpib();
    int c0;
    atn(8'h3e);
    chk(listen, 1, "listen at own address");
    c0 = n_cmd;
    send("OUT 1", 1'b1, 16'h0);
    await(c0, n_resp);
    chk(cmd_q.bool_val, 1, "bus command");
    atn(8'h3f);
    chk(listen, 0, "unlisten");
    c0 = n_cmd;
    send("OUT 1", 1'b1, 16'h0);
    repeat (5) @(negedge clk);
    chk(n_cmd, c0, "data while not listening");
    atn(8'h21);
    chk(listen, 0, "foreign address");
    atn(8'h5e);
    chk(talk, 1, "talk at own address");
    atn(8'h5f);
    chk(talk, 0, "untalk");
  endtask

  task automatic t_errs();
    int r0;
    send("XX  1", 1'b0, 16'd5024);
    wait_count(4'h1);
    chk(last, 1, "command error code");
    for (int c = 2; c < 11; c++) begin
      pulse(11'(c < 8 ? 1 << (12 - c) : 1 << (c - 6)));
      wait_count(4'(c));
    end
    pulse(11'h3);
    repeat (3) @(negedge clk);
    chk(cnt, 10, "full list holds");
    chk(last, 1, "oldest kept");
    r0 = n_resp;
    ser("ERR?");
    await(n_cmd, r0);
    chk(resp_q, 1, "serial query");
    for (int c = 2; c < 12; c++) begin
      r0 = n_resp;
      send(c[0] ? "ERROR?" : "ERR?", 1'b0, 16'd5025);
      await(n_cmd, r0);
      chk(resp_q, c < 11 ? c : 0, "oldest first");
      chk(cnt, c < 11 ? 10 - c : 0, "entry removed");
    end
    chk(last, 0, "empty status");
    pulse(11'h3);
    pulse(11'h2);
    wait_count(4'h2);
    chk(last, 11, "sync fault output on");
    r0 = n_resp;
    send("ERR?", 1'b0, 16'd5024);
    await(n_cmd, r0);
    chk(last, 12, "sync fault output off");
    send("*CLS", 1'b0, 16'd5024);
    wait_count(4'h0);
  endtask

  // A fault pulse that arrives while the enable is low must be lost.
  task automatic t_ce();
    ce = 1'b0;
    pulse(11'h400);
    repeat (3) @(negedge clk);
    chk(cnt, 0, "state frozen while disabled");
    ce = 1'b1;
    pulse(11'h400);
    wait_count(4'h1);
    chk(last, 2, "execution error code");
  endtask

  initial begin
    #200000;
    chk(0, 1, "run too long");
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    send_r = 1'b0;
    sbyte = 8'h00;
    addr = 5'h1e;
    ce = 1'b1;
    gpib = '0;
    lan = '0;
    fault = '0;
    sq = 16'h0000;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(cnt, 0, "count after reset");
    chk(last, 0, "status after reset");
    chk({gpib_rdy, lan_rdy}, 2'h3, "ready after reset");
    t_bool();
    t_num();
    t_str();
    t_gpib();
    t_errs();
    t_ce();
    end_of_test();
  end
endmodule
